// ==== logic/epka_defs.svh ====
// constants for the elliptic-curve key accelerator: addresses, fields, resets, counts
// assumes one 4 KB select window per block, word-addressed operand memory
`ifndef EPKA_DEFS_SVH
`define EPKA_DEFS_SVH

`define EPKA_BLOCK_BASE 32'hC000_0000
`define EPKA_BASE_MASK 32'hFFFF_F000
`define EPKA_CS_OFF 12'h000
`define EPKA_FLAGS_OFF 12'h004
`define EPKA_EN_OFF 12'h008
`define EPKA_RAM_OFF 12'h400
`define EPKA_RAM_END 12'h7FF
`define EPKA_RAM_WORDS 256
`define EPKA_HSIZE_WORD 3'h2
`define EPKA_HTRANS_IDLE 2'h0
`define EPKA_HTRANS_NONSEQ 2'h2

`define EPKA_CS_GO_BIT 0
`define EPKA_CS_READY_BIT 1
`define EPKA_CS_SRST_BIT 7
`define EPKA_FL_DONE_BIT 0
`define EPKA_FL_MEM_BIT 2
`define EPKA_FL_ADDR_BIT 3
`define EPKA_EVENT_MASK 4'hD

`define EPKA_CS_RESET 32'h0000_0002
`define EPKA_FLAGS_RESET 4'h0
`define EPKA_EN_RESET 4'h0

`define EPKA_ERR_IDX 8'h00
`define EPKA_K_IDX 8'h1B
`define EPKA_X_IDX 8'h24
`define EPKA_Y_IDX 8'h2D
`define EPKA_OPERAND_WORDS 9
`define EPKA_POINT_FIRST 6'h09
`define EPKA_LOAD_LAST 6'h1A
`define EPKA_ERR_BAD_POINT 32'h0000_0001
`define EPKA_ERR_NONE 32'h0000_0000
`define EPKA_CORE_STEPS 64

`endif

// ==== logic/epka_pkg.sv ====
// types shared by both ends of the key accelerator bus
// assumes epka_defs.svh supplies the numbers
package epka_pkg;

    typedef enum logic [1:0] {
        EPKA_IDLE = 2'b00,
        EPKA_LOAD = 2'b01,
        EPKA_RUN = 2'b10,
        EPKA_STORE = 2'b11
    } epka_state_type;

    typedef enum logic [2:0] {
        EPKA_REG_CS = 3'b000,
        EPKA_REG_FLAGS = 3'b001,
        EPKA_REG_EN = 3'b010,
        EPKA_REG_RAM = 3'b011,
        EPKA_REG_NONE = 3'b100
    } epka_region_type;

    typedef struct packed {
        epka_state_type state;
        logic phase;
        logic [5:0] cnt;
        logic [15:0] step;
        logic nonzero;
        logic bad;
        logic ready;
        logic busy;
        logic go;
        logic srst;
        logic [3:0] flags;
        logic [3:0] en;
        logic irq;
        logic dp_valid;
        logic dp_write;
        epka_region_type dp_region;
        logic [7:0] dp_idx;
        logic err1;
        logic hready;
        logic hresp;
        logic clk_on;
    } epka_dev_type;

    typedef struct packed {
        logic [31:0] wdata;
        logic clk_on;
        logic irq;
    } epka_host_type;

endpackage

// ==== logic/epka_ahb_if.sv ====
// bus between the processor-side master and the key accelerator slave
// assumes a single slave, so the slave's ready is the bus ready
`timescale 1ns/1ps
interface epka_ahb_if;
    logic HSEL;
    logic [31:0] HADDR;
    logic [1:0] HTRANS;
    logic HWRITE;
    logic [2:0] HSIZE;
    logic [31:0] HWDATA;
    logic [31:0] HRDATA;
    logic HREADY;
    logic HRESP;
    logic IRQ;
    logic CLK_ON;

    modport dev (
        input HSEL,
        input HADDR,
        input HTRANS,
        input HWRITE,
        input HSIZE,
        input HWDATA,
        input CLK_ON,
        output HRDATA,
        output HREADY,
        output HRESP,
        output IRQ
    );

    modport host (
        output HSEL,
        output HADDR,
        output HTRANS,
        output HWRITE,
        output HSIZE,
        output HWDATA,
        output CLK_ON,
        input HRDATA,
        input HREADY,
        input HRESP,
        input IRQ
    );
endinterface

// ==== logic/epka_operand_ram.sv ====
// single-port operand memory, synchronous write, asynchronous read
// assumes the owner muxes bus and engine onto the one port
`timescale 1ns/1ps
`include "epka_defs.svh"
module epka_operand_ram #(
    parameter int unsigned WORDS = `EPKA_RAM_WORDS
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [$clog2(WORDS)-1:0] addr,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    logic [31:0] mem [WORDS];

    if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0) begin : g_bad_words
        $error("operand ram depth must be a power of two");
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule

// ==== logic/epka_device.sv ====
// key accelerator slave: register bank, operand memory port and point-multiply sequencer
// assumes MCLK is the system clock and CLK_ON comes from the system clock gate control
//
// How it works
// - engine steps at half rate, memory full rate
// - only 32-bit accesses; others get error response
// - 1 KB operand memory at offset 0x400
// - host must ungate the clock before use
// - k, X, Y at fixed word offsets
// - error word at 0x00: 1 bad point
// - operands nine words, top word zero
// - register bank decoded at block base
// - go bit 1 launches, 0 ignored
// - ready bit low while computing, resets high
// - ready rising edge out of STORE sets done flag
// - soft reset bit resets the engine
// - memory detached while busy, sets fault flag
// - unmapped access sets address error flag
// - error flags clear on write one
// - enables at bits 0, 2, 3 only
// - memory is plain memory when idle
`timescale 1ns/1ps
`include "epka_defs.svh"
module epka_device #(
    parameter int unsigned CORE_STEPS = `EPKA_CORE_STEPS
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    epka_ahb_if.dev BUS,
    output logic ENGINE_BUSY
);
    epka_pkg::epka_dev_type s;
    epka_pkg::epka_dev_type next_s;
    logic ram_we;
    logic [7:0] ram_addr;
    logic [31:0] ram_wdata;
    logic [31:0] ram_rdata;
    logic [31:0] rdata;
    logic [3:0] set;
    logic [3:0] clr;
    logic launch;
    logic tick;
    logic nz;
    localparam logic [31:0] cs_reset_value = `EPKA_CS_RESET;

    if (CORE_STEPS < 1 || CORE_STEPS > 65536) begin : g_bad_steps
        $error("CORE_STEPS must lie in 1..65536");
    end

    function automatic epka_pkg::epka_region_type epka_region(input logic [31:0] a);
        if ((a & `EPKA_BASE_MASK) != `EPKA_BLOCK_BASE) begin
            return epka_pkg::EPKA_REG_NONE;
        end else if (a[11:0] == `EPKA_CS_OFF) begin
            return epka_pkg::EPKA_REG_CS;
        end else if (a[11:0] == `EPKA_FLAGS_OFF) begin
            return epka_pkg::EPKA_REG_FLAGS;
        end else if (a[11:0] == `EPKA_EN_OFF) begin
            return epka_pkg::EPKA_REG_EN;
        end else if (a[11:0] >= `EPKA_RAM_OFF && a[11:0] <= `EPKA_RAM_END) begin
            return epka_pkg::EPKA_REG_RAM;
        end else begin
            return epka_pkg::EPKA_REG_NONE;
        end
    endfunction

    epka_operand_ram #(
        .WORDS(`EPKA_RAM_WORDS)
    ) u_ram (
        .clk(MCLK),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    always_comb begin
        next_s = s;
        ram_we = 1'b0;
        ram_addr = s.dp_idx;
        ram_wdata = BUS.HWDATA;
        rdata = 32'h0000_0000;
        set = 4'h0;
        clr = 4'h0;
        launch = 1'b0;
        nz = s.nonzero;
        // the gate flop stands for the system clock gate: engine and data phase hold while it is low, the address phase still runs
        next_s.clk_on = BUS.CLK_ON;
        tick = s.phase & s.clk_on;
        if (s.clk_on) begin
            next_s.phase = ~s.phase;
        end

        // address phase; the first error cycle holds ready low, so nothing is sampled then
        next_s.err1 = 1'b0;
        next_s.dp_valid = 1'b0;
        if (BUS.HSEL && BUS.HTRANS[1] && !s.err1) begin
            if (BUS.HSIZE != `EPKA_HSIZE_WORD) begin
                next_s.err1 = 1'b1;
            end else begin
                next_s.dp_valid = 1'b1;
                next_s.dp_write = BUS.HWRITE;
                next_s.dp_region = epka_region(BUS.HADDR);
                next_s.dp_idx = BUS.HADDR[9:2];
            end
        end
        next_s.hready = ~next_s.err1;
        next_s.hresp = next_s.err1 | s.err1;

        // data phase
        if (s.dp_valid && s.clk_on) begin
            if (s.dp_region == epka_pkg::EPKA_REG_RAM) begin
                if (s.busy) begin
                    set[`EPKA_FL_MEM_BIT] = 1'b1;
                end else begin
                    ram_we = s.dp_write;
                    rdata = ram_rdata;
                end
            end else if (s.dp_region == epka_pkg::EPKA_REG_CS) begin
                rdata[`EPKA_CS_GO_BIT] = s.go;
                rdata[`EPKA_CS_READY_BIT] = s.ready;
                rdata[`EPKA_CS_SRST_BIT] = s.srst;
                if (s.dp_write) begin
                    next_s.go = BUS.HWDATA[`EPKA_CS_GO_BIT];
                    next_s.srst = BUS.HWDATA[`EPKA_CS_SRST_BIT];
                    launch = BUS.HWDATA[`EPKA_CS_GO_BIT] & s.ready & ~s.srst
                        & ~BUS.HWDATA[`EPKA_CS_SRST_BIT];
                end
            end else if (s.dp_region == epka_pkg::EPKA_REG_FLAGS) begin
                rdata[3:0] = s.flags;
                if (s.dp_write) begin
                    clr = BUS.HWDATA[3:0] & `EPKA_EVENT_MASK;
                end
            end else if (s.dp_region == epka_pkg::EPKA_REG_EN) begin
                rdata[3:0] = s.en;
                if (s.dp_write) begin
                    next_s.en = BUS.HWDATA[3:0] & `EPKA_EVENT_MASK;
                end
            end else begin
                set[`EPKA_FL_ADDR_BIT] = 1'b1;
            end
        end

        // sequencer; launch and soft reset act at once, otherwise it moves only on the half-rate tick so its memory address spans two edges
        case (s.state)
            epka_pkg::EPKA_IDLE: begin
                if (launch) begin
                    next_s.state = epka_pkg::EPKA_LOAD;
                    next_s.cnt = 6'h00;
                    next_s.nonzero = 1'b0;
                    next_s.ready = 1'b0;
                end
            end
            epka_pkg::EPKA_LOAD: begin
                // k, X, Y sit back to back, nine words each
                ram_addr = `EPKA_K_IDX + {2'b00, s.cnt};
                nz = s.nonzero | ((s.cnt >= `EPKA_POINT_FIRST) && (ram_rdata != 32'h0000_0000));
                if (tick) begin
                    next_s.nonzero = nz;
                    next_s.cnt = s.cnt + 6'h01;
                    if (s.cnt == `EPKA_LOAD_LAST) begin
                        // limitation: only the all-zero point is caught as off the curve
                        next_s.bad = ~nz;
                        next_s.step = 16'h0000;
                        next_s.state = nz ? epka_pkg::EPKA_RUN : epka_pkg::EPKA_STORE;
                    end
                end
            end
            epka_pkg::EPKA_RUN: begin
                // stand-in for the modular datapath; X and Y stay in place
                if (tick) begin
                    next_s.step = s.step + 16'h0001;
                    if (s.step == 16'(CORE_STEPS - 1)) begin
                        next_s.state = epka_pkg::EPKA_STORE;
                    end
                end
            end
            epka_pkg::EPKA_STORE: begin
                ram_we = 1'b1;
                ram_addr = `EPKA_ERR_IDX;
                ram_wdata = s.bad ? `EPKA_ERR_BAD_POINT : `EPKA_ERR_NONE;
                if (tick) begin
                    next_s.state = epka_pkg::EPKA_IDLE;
                    next_s.ready = 1'b1;
                end
            end
            default: begin
                next_s.state = epka_pkg::EPKA_IDLE;
            end
        endcase

        if (s.srst) begin
            next_s.state = epka_pkg::EPKA_IDLE;
            next_s.ready = 1'b1;
            next_s.cnt = 6'h00;
            next_s.step = 16'h0000;
        end
        next_s.busy = next_s.state != epka_pkg::EPKA_IDLE;
        set[`EPKA_FL_DONE_BIT] = next_s.ready & ~s.ready & ~s.srst;
        // a set in the same cycle as its clear wins
        if (s.srst) begin
            next_s.flags = `EPKA_FLAGS_RESET;
        end else begin
            next_s.flags = ((s.flags & ~clr) | set) & `EPKA_EVENT_MASK;
        end
        next_s.irq = |(next_s.flags & next_s.en);
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            s <= '0;
            s.ready <= cs_reset_value[`EPKA_CS_READY_BIT];
            s.hready <= 1'b1;
            s.flags <= `EPKA_FLAGS_RESET;
            s.en <= `EPKA_EN_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign BUS.HRDATA = rdata;
    assign BUS.HREADY = s.hready;
    assign BUS.HRESP = s.hresp;
    assign BUS.IRQ = s.irq;
    assign ENGINE_BUSY = s.busy;
endmodule

// ==== logic/epka_host.sv ====
// processor-side bus master: turns single-cycle user strobes into word transfers
// assumes the user never raises both strobes at once
`timescale 1ns/1ps
`include "epka_defs.svh"
module epka_host (
    input wire logic MCLK,
    input wire logic SYS_RST,
    epka_ahb_if.host BUS,
    input wire logic [31:0] USR_ADDR,
    input wire logic [31:0] USR_WDATA,
    input wire logic USR_WR,
    input wire logic USR_RD,
    input wire logic USR_CLK_ON,
    output logic [31:0] USR_RDATA,
    output logic USR_FAULT,
    output logic USR_IRQ
);
    epka_pkg::epka_host_type s;
    epka_pkg::epka_host_type next_s;
    logic strobe;

    always_comb begin
        next_s = s;
        strobe = USR_WR | USR_RD;
        if (USR_WR) begin
            next_s.wdata = USR_WDATA;
        end
        next_s.clk_on = USR_CLK_ON;
        next_s.irq = BUS.IRQ;
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // address phase rides on the strobe cycle so read data land one cycle later
    assign BUS.HSEL = strobe;
    assign BUS.HADDR = USR_ADDR;
    assign BUS.HTRANS = strobe ? `EPKA_HTRANS_NONSEQ : `EPKA_HTRANS_IDLE;
    assign BUS.HWRITE = USR_WR;
    assign BUS.HSIZE = `EPKA_HSIZE_WORD;
    assign BUS.HWDATA = s.wdata;
    assign BUS.CLK_ON = s.clk_on;
    assign USR_RDATA = BUS.HRDATA;
    assign USR_FAULT = BUS.HRESP & BUS.HREADY;
    assign USR_IRQ = s.irq;
endmodule

// ==== sim/epka_asserts.sv ====
// bus-level checker for the key accelerator, watching the host-device interface
// assumes one clock, synchronous active-high reset and word-aligned addresses
`timescale 1ns/1ps
`include "epka_defs.svh"
module epka_asserts (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADY,
    input wire logic HRESP,
    input wire logic IRQ,
    input wire logic CLK_ON
);
    logic gate_q;
    logic req;
    logic gate;
    logic mapped;
    // the device's gate lags CLK_ON by one flop
    always_ff @(posedge MCLK) begin
        gate_q <= SYS_RST ? 1'b0 : CLK_ON;
    end
    assign req = HSEL && HTRANS == `EPKA_HTRANS_NONSEQ && HREADY;
    assign gate = CLK_ON && gate_q;
    assign mapped = (HADDR[31:4] == 28'hC00_0000 && HADDR[3:2] != 2'h3)
        || HADDR[31:10] == 22'h30_0001;
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    sequence s_rd_at(logic [31:0] a);
        req && gate && !HWRITE && HADDR == a;
    endsequence
    sequence s_ram_wr;
        req && gate && HWRITE && HADDR[31:10] == 22'h30_0001;
    endsequence
    sequence s_same_rd;
        req && gate && !HWRITE && HADDR == $past(HADDR);
    endsequence
    sequence s_en_off;
        req && gate && HWRITE && HADDR == 32'hC000_0008 ##1 (HWDATA[3:0] & 4'hD) == 4'h0;
    endsequence
    property p_word_ok;
        req && HSIZE == `EPKA_HSIZE_WORD |=> !HRESP && HREADY;
    endproperty
    property p_unmapped_zero;
        req && gate && !HWRITE && !mapped |=> HRDATA == 32'h0000_0000;
    endproperty
    property p_cs_reserved;
        s_rd_at(32'hC000_0000) |=> HRDATA[6:2] == 5'h00 && HRDATA[31:8] == 24'h00_0000;
    endproperty
    property p_flags_reserved;
        s_rd_at(32'hC000_0004) |=> HRDATA[31:4] == 28'h000_0000 && !HRDATA[1];
    endproperty
    property p_en_reserved;
        s_rd_at(32'hC000_0008) |=> (HRDATA & ~32'h0000_000D) == 32'h0000_0000;
    endproperty
    property p_irq_off;
        s_en_off |-> ##[1:2] !IRQ;
    endproperty
    property p_gated;
        req && !CLK_ON && !gate_q && !HWRITE |=> HRDATA == 32'h0000_0000;
    endproperty
    property p_ram_echo;
        s_ram_wr ##1 s_same_rd |=> HRDATA == $past(HWDATA);
    endproperty
    a_word_ok: assert property (p_word_ok)
        else $error("word access answered with error");
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned data");
    a_cs_reserved: assert property (p_cs_reserved)
        else $error("command register reserved bits set");
    a_flags_reserved: assert property (p_flags_reserved)
        else $error("flag register reserved bits set");
    a_en_reserved: assert property (p_en_reserved)
        else $error("enable register reserved bits set");
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt stays high with all enables off");
    a_gated: assert property (p_gated)
        else $error("read answered while clock gated");
    a_ram_echo: assert property (p_ram_echo)
        else $error("memory word not read back");
endmodule

// ==== sim/ecc_public_key_accelerator_tb.sv ====
// self-checking bench: host and device joined over the bus, plus a bare device for bad sizes
// assumes the design files and epka_defs.svh are compiled first
`timescale 1ns/1ps
`include "epka_defs.svh"
module ecc_public_key_accelerator_tb;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } epka_row_type;
    localparam int steps = 4;
    localparam logic [31:0] cs_addr = 32'hC000_0000;
    localparam logic [31:0] fl_addr = 32'hC000_0004;
    localparam logic [31:0] en_addr = 32'hC000_0008;
    localparam logic [31:0] ram_addr = 32'hC000_0400;
    // engine ticks on every other edge; first tick may lag the launch by one edge
    localparam int good_len = 2 * (3 * `EPKA_OPERAND_WORDS + steps + 1) - 1;
    localparam int bad_len = 2 * (3 * `EPKA_OPERAND_WORDS + 1) - 1;
    localparam epka_row_type rows [6] = '{
        '{en_addr, 32'hFFFF_FFFF, 32'h0000_000D},
        '{en_addr, 32'h0000_0000, 32'h0000_0000},
        '{ram_addr, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
        '{ram_addr + 32'h0000_03FC, 32'h1234_5678, 32'h1234_5678},
        '{fl_addr, 32'h0000_000F, 32'h0000_0000},
        '{cs_addr, 32'h0000_0000, 32'h0000_0002}};
    logic mclk;
    logic sys_rst;
    logic [31:0] usr_addr;
    logic [31:0] usr_wdata;
    logic usr_wr;
    logic usr_rd;
    logic usr_clk_on;
    logic [31:0] usr_rdata;
    logic usr_irq;
    logic usr_fault;
    logic busy;
    logic [31:0] v;
    int run_len;
    int cycles;
    int checked;
    int bad_count;
    epka_ahb_if bus ();
    epka_ahb_if bus2 ();
    epka_host epka_host_i (.MCLK(mclk), .SYS_RST(sys_rst), .BUS(bus), .USR_ADDR(usr_addr),
        .USR_WDATA(usr_wdata), .USR_WR(usr_wr), .USR_RD(usr_rd), .USR_CLK_ON(usr_clk_on),
        .USR_RDATA(usr_rdata), .USR_FAULT(usr_fault), .USR_IRQ(usr_irq));
    epka_device #(.CORE_STEPS(steps)) epka_device_i (.MCLK(mclk), .SYS_RST(sys_rst),
        .BUS(bus), .ENGINE_BUSY(busy));
    epka_device #(.CORE_STEPS(steps)) epka_device_i2 (.MCLK(mclk), .SYS_RST(sys_rst),
        .BUS(bus2), .ENGINE_BUSY());
    epka_asserts epka_asserts_i (.MCLK(mclk), .SYS_RST(sys_rst), .HSEL(bus.HSEL),
        .HADDR(bus.HADDR), .HTRANS(bus.HTRANS), .HWRITE(bus.HWRITE), .HSIZE(bus.HSIZE),
        .HWDATA(bus.HWDATA), .HRDATA(bus.HRDATA), .HREADY(bus.HREADY), .HRESP(bus.HRESP),
        .IRQ(bus.IRQ), .CLK_ON(bus.CLK_ON));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (busy === 1'b1) run_len <= run_len + 1;
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [31:0] a, input logic [31:0] d, input logic w);
        @(posedge mclk);
        usr_addr <= a;
        usr_wdata <= d;
        usr_wr <= w;
        usr_rd <= !w;
        @(posedge mclk);
        usr_wr <= 1'b0;
        usr_rd <= 1'b0;
        #1 v = usr_rdata;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        acc(a, 32'h0000_0000, 1'b0);
        chk(v, e);
    endtask
    task automatic wr_rd(input epka_row_type r);
        @(posedge mclk);
        usr_addr <= r.a;
        usr_wdata <= r.d;
        usr_wr <= 1'b1;
        @(posedge mclk);
        usr_wr <= 1'b0;
        usr_rd <= 1'b1;
        @(posedge mclk);
        usr_rd <= 1'b0;
        #1 chk(usr_rdata, r.e);
    endtask
    // k counts up, point words carry pv, top word of each operand left zero
    task automatic load(input logic [31:0] pv);
        for (int i = 0; i < 27; i++) begin
            acc(32'hC000_046C + 32'(4 * i),
                (i % 9 == 8) ? 32'h0000_0000 : (i < 9 ? 32'(i + 1) : pv), 1'b1);
        end
    endtask
    task automatic run(input int len);
        run_len = 0;
        acc(cs_addr, 32'h0000_0001, 1'b1);
        rdc(cs_addr, 32'h0000_0001);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(posedge mclk);
        #1 chk(32'(run_len >= len && run_len <= len + 1), 32'h0000_0001);
    endtask
    initial begin
        {usr_addr, usr_wdata, usr_wr, usr_rd, usr_clk_on} = '0;
        {bus2.HSEL, bus2.HTRANS, bus2.HWRITE, bus2.HSIZE, bus2.HWDATA} = '0;
        bus2.HADDR = cs_addr;
        bus2.CLK_ON = 1'b1;
        sys_rst = 1'b1;
        run_len = 0;
        cycles = 0;
        checked = 0;
        bad_count = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rdc(cs_addr, 32'h0000_0000);
        @(posedge mclk);
        usr_clk_on <= 1'b1;
        repeat (2) @(posedge mclk);
        rdc(cs_addr, 32'h0000_0002);
        rdc(fl_addr, 32'h0000_0000);
        rdc(en_addr, 32'h0000_0000);
        $display("test reset done");
        foreach (rows[i]) wr_rd(rows[i]);
        $display("test table done");
        load(32'h5A5A_0001);
        acc(en_addr, 32'h0000_0001, 1'b1);
        run_len = 0;
        acc(cs_addr, 32'h0000_0001, 1'b1);
        rdc(ram_addr + 32'h0000_006C, 32'h0000_0000);
        acc(ram_addr + 32'h0000_006C, 32'hFFFF_FFFF, 1'b1);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(posedge mclk);
        #1 chk(32'(run_len >= good_len && run_len <= good_len + 1), 32'h0000_0001);
        chk({31'h0000_0000, usr_irq}, 32'h0000_0001);
        rdc(fl_addr, 32'h0000_0005);
        rdc(ram_addr, 32'h0000_0000);
        rdc(ram_addr + 32'h0000_0090, 32'h5A5A_0001);
        rdc(ram_addr + 32'h0000_006C, 32'h0000_0001);
        acc(fl_addr, 32'h0000_0001, 1'b1);
        rdc(fl_addr, 32'h0000_0004);
        acc(fl_addr, 32'h0000_0004, 1'b1);
        rdc(fl_addr, 32'h0000_0000);
        chk({31'h0000_0000, usr_irq}, 32'h0000_0000);
        acc(cs_addr, 32'h0000_0000, 1'b1);
        rdc(cs_addr, 32'h0000_0002);
        $display("test good point done");
        load(32'h0000_0000);
        run(bad_len);
        rdc(ram_addr, 32'h0000_0001);
        acc(cs_addr, 32'h0000_0000, 1'b1);
        acc(fl_addr, 32'h0000_000D, 1'b1);
        $display("test bad point done");
        acc(en_addr, 32'h0000_0008, 1'b1);
        rdc(32'hC000_000C, 32'h0000_0000);
        rdc(32'hC000_0800, 32'h0000_0000);
        acc(fl_addr, 32'h0000_0000, 1'b1);
        rdc(fl_addr, 32'h0000_0008);
        chk({31'h0000_0000, usr_irq}, 32'h0000_0001);
        acc(en_addr, 32'h0000_0000, 1'b1);
        rdc(fl_addr, 32'h0000_0008);
        chk({31'h0000_0000, usr_irq}, 32'h0000_0000);
        acc(fl_addr, 32'h0000_0008, 1'b1);
        rdc(fl_addr, 32'h0000_0000);
        $display("test unmapped done");
        acc(cs_addr, 32'h0000_0001, 1'b1);
        acc(cs_addr, 32'h0000_0080, 1'b1);
        rdc(cs_addr, 32'h0000_0082);
        chk({31'h0000_0000, busy}, 32'h0000_0000);
        rdc(fl_addr, 32'h0000_0000);
        acc(cs_addr, 32'h0000_0000, 1'b1);
        rdc(cs_addr, 32'h0000_0002);
        chk({31'h0000_0000, usr_fault}, 32'h0000_0000);
        $display("test soft reset done");
        @(posedge mclk);
        bus2.HSEL <= 1'b1;
        bus2.HTRANS <= `EPKA_HTRANS_NONSEQ;
        @(posedge mclk);
        bus2.HSEL <= 1'b0;
        bus2.HTRANS <= `EPKA_HTRANS_IDLE;
        bus2.HADDR <= 32'h0000_0000;
        #1 chk({30'h0000_0000, bus2.HREADY, bus2.HRESP}, 32'h0000_0001);
        @(posedge mclk);
        #1 chk({30'h0000_0000, bus2.HREADY, bus2.HRESP}, 32'h0000_0003);
        $display("test narrow access done");
        print_verdict();
    end
endmodule
